// >>> shared/brg_map.vh
// register map and constants for the bit rate generator with dpll
`ifndef BRG_MAP_VH
`define BRG_MAP_VH
// register indices on the plain register port
`define BRG_ADDR_TX_COR 4'h0
`define BRG_ADDR_RX_COR 4'h1
`define BRG_ADDR_TX_BPR 4'h2
`define BRG_ADDR_RX_BPR 4'h3
`define BRG_ADDR_STATUS 4'h4
// clock option fields
`define BRG_TX_SEL_HI 7
`define BRG_TX_SEL_LO 5
`define BRG_RX_SEL_HI 2
`define BRG_RX_SEL_LO 0
`define BRG_RX_DPLL_BIT 5
// source select codes
`define BRG_SEL_CLK0 3'h0
`define BRG_SEL_CLK1 3'h1
`define BRG_SEL_CLK2 3'h2
`define BRG_SEL_CLK3 3'h3
`define BRG_SEL_CLK4 3'h4
`define BRG_SEL_EXT 3'h6
`define BRG_SEL_RX_EXTERNAL_CLOCK_PIN 3'h7
// reset values
`define BRG_COR_RST 8'h00
`define BRG_BPR_RST 8'h01
// prescaler tap bits: /8,/32,/128,/512,/2048
`define BRG_TAP0 2
`define BRG_TAP1 4
`define BRG_TAP2 6
`define BRG_TAP3 8
`define BRG_TAP4 10
`define BRG_PRE_W 11
`endif

// >>> rtl/brg_dpll.v
// per-direction bit rate generator with receive dpll, one serial channel
`include "brg_map.vh"

// Functional notes
// - separate source select and divisor for transmit and receive
// - five taps from system clock: divide by 8, 32, 128, 512, 2048
// - tx may use its external pin or rx bit clock; rx its pin
// - divisor 1 to 255 held in 8-bit period register per direction
// - period 01h with external clock uses that clock directly
// - external clock at bit-rate multiple divided by loaded period plus one
// - dpll mode recentres rx clock phase to mid-cell on each incoming data transition, except with period 01h on the external clock
// - tx selecting rx bit clock is clocked by recovered rx clock
// - writing 00h to clock option selects tap zero
// - select codes: 000-100 taps, 110 external, 111 rx clock for tx
// - external rx clock: data sampled on its rising edge
module brg_dpll
(
   // clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // register port
   input wire [3:0] addr_in,
   input wire [7:0] wr_data_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rd_data_out,
   // line pins
   input wire tx_external_clock_pin_in,
   input wire rx_external_clock_pin_in,
   input wire rx_data_in,
   // bit clock enables and sampled data
   output reg tx_bit_clk_out,
   output reg rx_bit_clk_out,
   output reg rx_data_sample_out
);

   // registers
   reg [7:0] tx_clock_option_reg_r;
   reg [7:0] rx_clock_option_reg_r;
   reg [7:0] tx_bit_period_reg_r;
   reg [7:0] rx_bit_period_reg_r;
   reg [`BRG_PRE_W-1:0] pre_r;
   reg [`BRG_PRE_W-1:0] pre_nxt;
   reg [7:0] tx_cnt_r;
   reg [7:0] rx_cnt_r;
   reg tx_reload_r;
   reg rx_reload_r;
   // pin synchronisers: first stage read only by second stage
   reg txc_s1_r, txc_s2_r, txc_s3_r;
   reg rxc_s1_r, rxc_s2_r, rxc_s3_r;
   reg rxd_s1_r, rxd_s2_r, rxd_s3_r;
   reg [7:0] rd_data_nxt;

   wire [2:0] tx_sel = tx_clock_option_reg_r[`BRG_TX_SEL_HI:`BRG_TX_SEL_LO];
   wire [2:0] rx_sel = rx_clock_option_reg_r[`BRG_RX_SEL_HI:`BRG_RX_SEL_LO];
   wire dpll_en = rx_clock_option_reg_r[`BRG_RX_DPLL_BIT];
   wire txc_rise = txc_s2_r & ~txc_s3_r;
   wire rxc_rise = rxc_s2_r & ~rxc_s3_r;
   wire rxd_edge = rxd_s2_r ^ rxd_s3_r;

   // tick from a prescaler tap: one cycle when all low bits wrap
   function tap_tick;
      input [`BRG_PRE_W-1:0] p;
      input [2:0] sel;
      begin
         case (sel)
            `BRG_SEL_CLK0: tap_tick = &p[`BRG_TAP0:0];
            `BRG_SEL_CLK1: tap_tick = &p[`BRG_TAP1:0];
            `BRG_SEL_CLK2: tap_tick = &p[`BRG_TAP2:0];
            `BRG_SEL_CLK3: tap_tick = &p[`BRG_TAP3:0];
            `BRG_SEL_CLK4: tap_tick = &p[`BRG_TAP4:0];
            default: tap_tick = 1'b0; // 101 reserved gives no clock
         endcase
      end
   endfunction

   // next divider count on a source tick: wrap back to the period at zero
   function [7:0] count_next;
      input [7:0] cnt;
      input [7:0] period;
      begin
         if (cnt == 8'h00)
            count_next = period;
         else
            count_next = cnt - 8'h01;
      end
   endfunction

   // zero is outside 1..255; held at 1 so the divider never stalls
   function [7:0] legal_period;
      input [7:0] value;
      begin
         if (value == 8'h00)
            legal_period = `BRG_BPR_RST;
         else
            legal_period = value;
      end
   endfunction

   // source tick per direction
   wire rx_tick = (rx_sel == `BRG_SEL_EXT) ? rxc_rise : tap_tick(pre_r, rx_sel);
   wire tx_tick = (tx_sel == `BRG_SEL_EXT) ? txc_rise :
                  (tx_sel == `BRG_SEL_RX_EXTERNAL_CLOCK_PIN) ? rx_bit_clk_out :
                  tap_tick(pre_r, tx_sel);

   // down counters: terminal at zero gives period+1 ticks
   wire tx_term = tx_tick & (tx_cnt_r == 8'h00);
   wire rx_term = rx_tick & (rx_cnt_r == 8'h00);
   // period 01h with an external 1x clock passes every rising edge through
   wire tx_direct = (tx_sel != `BRG_SEL_CLK0) && (tx_sel >= `BRG_SEL_EXT) &&
                    (tx_bit_period_reg_r == `BRG_BPR_RST);
   wire rx_direct = (rx_sel == `BRG_SEL_EXT) && (rx_bit_period_reg_r == `BRG_BPR_RST);
   wire [7:0] rx_half = {1'b0, rx_bit_period_reg_r[7:1]};

   // free running prescaler
   always @*
   begin
      pre_nxt = pre_r + {{(`BRG_PRE_W-1){1'b0}}, 1'b1};
   end

   // read mux; status shows the receive counter's live state
   always @*
   begin
      case (addr_in)
         `BRG_ADDR_TX_COR: rd_data_nxt = tx_clock_option_reg_r;
         `BRG_ADDR_RX_COR: rd_data_nxt = rx_clock_option_reg_r;
         `BRG_ADDR_TX_BPR: rd_data_nxt = tx_bit_period_reg_r;
         `BRG_ADDR_RX_BPR: rd_data_nxt = rx_bit_period_reg_r;
         `BRG_ADDR_STATUS: rd_data_nxt = rx_cnt_r;
         default: rd_data_nxt = 8'h00;
      endcase
   end

   // register writes and read data
   always @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         tx_clock_option_reg_r <= `BRG_COR_RST;
         rx_clock_option_reg_r <= `BRG_COR_RST;
         tx_bit_period_reg_r <= `BRG_BPR_RST;
         rx_bit_period_reg_r <= `BRG_BPR_RST;
         tx_reload_r <= 1'b0;
         rx_reload_r <= 1'b0;
         rd_data_out <= 8'h00;
      end
      else
      begin
         tx_reload_r <= wr_in && (addr_in == `BRG_ADDR_TX_BPR);
         rx_reload_r <= wr_in && (addr_in == `BRG_ADDR_RX_BPR);
         rd_data_out <= rd_in ? rd_data_nxt : 8'h00;
         if (wr_in)
         begin
            case (addr_in)
               `BRG_ADDR_TX_COR: tx_clock_option_reg_r <= wr_data_in;
               `BRG_ADDR_RX_COR: rx_clock_option_reg_r <= wr_data_in;
               `BRG_ADDR_TX_BPR: tx_bit_period_reg_r <= legal_period(wr_data_in);
               `BRG_ADDR_RX_BPR: rx_bit_period_reg_r <= legal_period(wr_data_in);
               default: ;
            endcase
         end
      end
   end

   // synchronisers for the external pins; fine below clk/16
   always @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         {txc_s1_r, txc_s2_r, txc_s3_r} <= 3'h0;
         {rxc_s1_r, rxc_s2_r, rxc_s3_r} <= 3'h0;
         {rxd_s1_r, rxd_s2_r, rxd_s3_r} <= 3'h0;
      end
      else
      begin
         txc_s1_r <= tx_external_clock_pin_in;
         txc_s2_r <= txc_s1_r;
         txc_s3_r <= txc_s2_r;
         rxc_s1_r <= rx_external_clock_pin_in;
         rxc_s2_r <= rxc_s1_r;
         rxc_s3_r <= rxc_s2_r;
         rxd_s1_r <= rx_data_in;
         rxd_s2_r <= rxd_s1_r;
         rxd_s3_r <= rxd_s2_r;
      end
   end

   // divider chains and dpll
   always @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         pre_r <= {`BRG_PRE_W{1'b0}};
         tx_cnt_r <= `BRG_BPR_RST;
         rx_cnt_r <= `BRG_BPR_RST;
         tx_bit_clk_out <= 1'b0;
         rx_bit_clk_out <= 1'b0;
         rx_data_sample_out <= 1'b0;
      end
      else
      begin
         pre_r <= pre_nxt;
         // transmit divider
         if (tx_reload_r)
            tx_cnt_r <= tx_bit_period_reg_r;
         else if (tx_tick)
            tx_cnt_r <= count_next(tx_cnt_r, tx_bit_period_reg_r);
         tx_bit_clk_out <= tx_direct ? tx_tick : (tx_term & ~tx_reload_r);
         // receive divider; dpll recentres on a data edge so the bit
         // clock lands mid-cell, trading jitter for fast lock
         if (rx_reload_r)
            rx_cnt_r <= rx_bit_period_reg_r;
         else if (dpll_en && rxd_edge && !rx_direct)
            rx_cnt_r <= rx_half;
         else if (rx_tick)
            rx_cnt_r <= count_next(rx_cnt_r, rx_bit_period_reg_r);
         rx_bit_clk_out <= rx_direct ? rx_tick : (rx_term & ~rx_reload_r);
         // sample only with a bit clock actually sent, so a reload never moves it
         if (rx_direct ? rx_tick : (rx_term & ~rx_reload_r))
            rx_data_sample_out <= rxd_s2_r;
      end
   end

endmodule // brg_dpll

// >>> test/brg_dpll_properties.sv
// port checker for the bit rate generator
module brg_dpll_properties
(
   input wire logic sys_clk_in, rst_in, wr_in, rd_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wr_data_in, rd_data_out,
   input wire logic tx_bit_clk_out, rx_bit_clk_out, rx_data_sample_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_idle; !rd_in |=> rd_data_out == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("stray read data");
   property p_txgap; tx_bit_clk_out |=> !tx_bit_clk_out [*7]; endproperty
   a_txgap: assert property (p_txgap) else $error("tx pulses close");
   property p_rxgap; rx_bit_clk_out |=> !rx_bit_clk_out [*7]; endproperty
   a_rxgap: assert property (p_rxgap) else $error("rx pulses close");
   // sampled data may only move with a receive bit clock
   property p_smp; $changed(rx_data_sample_out) |-> rx_bit_clk_out || $past(rx_bit_clk_out);
   endproperty
   a_smp: assert property (p_smp) else $error("sample off clock");
   property p_txsel; (wr_in && addr_in == 4'h0) ##1 (rd_in && addr_in == 4'h0)
      |=> ((rd_data_out ^ $past(wr_data_in, 2)) & 8'he0) == 8'h00; endproperty
   a_txsel: assert property (p_txsel) else $error("tx select lost");
   property p_rxsel; (wr_in && addr_in == 4'h1) ##1 (rd_in && addr_in == 4'h1)
      |=> ((rd_data_out ^ $past(wr_data_in, 2)) & 8'h27) == 8'h00; endproperty
   a_rxsel: assert property (p_rxsel) else $error("rx select lost");
   property p_zero; (wr_in && addr_in == 4'h2 && wr_data_in == 8'h00)
      ##1 (rd_in && addr_in == 4'h2) |=> rd_data_out == 8'h01; endproperty
   a_zero: assert property (p_zero) else $error("zero period kept");
   property p_unmap; rd_in && addr_in > 4'h4 |=> rd_data_out == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule // brg_dpll_properties

bind brg_dpll brg_dpll_properties chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
   .wr_in(wr_in), .rd_in(rd_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
   .rd_data_out(rd_data_out), .tx_bit_clk_out(tx_bit_clk_out),
   .rx_bit_clk_out(rx_bit_clk_out), .rx_data_sample_out(rx_data_sample_out));

// >>> test/brg_line_model.sv
// far side model: external line clock and receive data
module brg_line_model
(
   input wire logic run_in,
   output logic clk_out,
   output logic data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pat = 8'hb4;
   initial clk_out = 1'b0;
   initial data_out = 1'b0;
   // 1 MHz, well under a sixteenth of the system clock
   always #500
   begin
      if (run_in || clk_out)
      begin
         clk_out = ~clk_out;
         // data moves on the falling edge so rising edges see it settled
         if (!clk_out)
         begin
            pat = {pat[6:0], pat[7]};
            data_out = pat[0];
         end
      end
      else
         data_out = ~data_out; // idle line never holds a stale level
   end
endmodule // brg_line_model

// >>> test/brg_dpll_bench.sv
// self-checking bench for the bit rate generator
module brg_dpll_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, wr = 0, rd = 0, run = 0;
   logic [3:0] a = 4'h0;
   logic [7:0] d = 8'h00, v;
   logic [31:0] seed = 32'haea7_4d43;
   wire [7:0] q;
   wire ec, dl, tb, rb, smp;
   int fails = 0, n_compared = 0, k, n;
   brg_dpll dut (.sys_clk_in(clk), .rst_in(rst), .addr_in(a), .wr_data_in(d), .wr_in(wr),
      .rd_in(rd), .rd_data_out(q), .tx_external_clock_pin_in(ec),
      .rx_external_clock_pin_in(ec), .rx_data_in(dl), .tx_bit_clk_out(tb),
      .rx_bit_clk_out(rb), .rx_data_sample_out(smp));
   brg_line_model line (.run_in(run), .clk_out(ec), .data_out(dl));
   initial forever #12.5 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // cycles between pulses: period plus one ticks of the tap
   function automatic logic [15:0] gapx(input int tap, input logic [7:0] p);
      return (16'd1 + p) << (3 + 2 * tap);
   endfunction
   task automatic chk(input string nm, input logic [15:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic report_and_stop();
      if (fails == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic bus(input logic w, r, input logic [3:0] ad, input logic [7:0] dt);
      @(posedge clk);
      wr <= w;
      rd <= r;
      a <= ad;
      d <= dt;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rdchk(input logic [3:0] ad, input logic [7:0] m, e);
      bus(0, 1, ad, 0);
      bus(0, 0, ad, 0);
      #1 chk("rd_data_out", q & m, e & m);
   endtask
   task automatic cfg(input logic [2:0] ts, rs, input logic [7:0] tp, rp);
      bus(1, 0, 4'h0, {ts, 5'h00});
      bus(1, 0, 4'h1, {5'h00, rs});
      bus(1, 0, 4'h2, tp);
      bus(1, 0, 4'h3, rp);
      bus(0, 0, 4'h0, 8'h00);
   endtask
   // skip to one pulse, then count cycles to the next
   task automatic gap(input logic sel_rx, input logic [15:0] e);
      #1;
      for (k = 0; k < 9000 && !(sel_rx ? rb : tb); k++) @(posedge clk) #1;
      for (n = 1; n < 9000 && (k < 9000); n++)
      begin
         @(posedge clk) #1;
         if (sel_rx ? rb : tb) break;
      end
      chk("bit clock gap", n[15:0], e);
      if (k >= 9000 || n >= 9000) report_and_stop();
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rdchk(4'h0, 8'hff, 8'h00);
      rdchk(4'h1, 8'hff, 8'h00);
      rdchk(4'h3, 8'hff, 8'h01);
      rdchk(4'h4, 8'hfe, 8'h00);
      bus(1, 0, 4'h9, 8'h5a);
      rdchk(4'hf, 8'hff, 8'h00);
      bus(1, 0, 4'h2, 8'h00);
      rdchk(4'h2, 8'hff, 8'h01);
      repeat (12)
      begin
         seed = xs(seed);
         v = seed[15:8];
         bus(1, 0, {2'b00, seed[1:0]}, v);
         rdchk({2'b00, seed[1:0]}, seed[1:0] == 0 ? 8'he0 : seed[1:0] == 1 ? 8'h27 : 8'hff,
            seed[1] && v == 0 ? 8'h01 : v);
      end
      for (int t = 0; t < 5; t++)
      begin
         cfg(t[2:0], t[2:0], t == 0 ? 8'hff : 8'h01, 8'h02);
         gap(0, gapx(t, t == 0 ? 8'hff : 8'h01));
         gap(1, gapx(t, 8'h02));
      end
      run <= 1'b1;
      cfg(3'h6, 3'h6, 8'h01, 8'h02);
      gap(0, 16'd40);
      gap(1, 16'd120);
      cfg(3'h7, 3'h6, 8'h01, 8'h02);
      gap(0, 16'd120);
      // sampled data must match the line level at the external rising edge
      for (int i = 0; i < 4; i++)
      begin
         for (k = 0; k < 300 && !rb; k++) @(posedge clk) #1;
         chk("rx_data_sample_out", {15'h0000, smp}, {15'h0000, dl});
         if (k >= 300) report_and_stop();
         @(posedge clk) #1;
      end
      cfg(3'h5, 3'h6, 8'h01, 8'h02);
      n = 0;
      repeat (300) @(posedge clk) #1 n += tb;
      chk("reserved code pulses", n[15:0], 16'h0000);
      // dpll on tap zero: data edges keep recentring, so no pulse in 2500 cycles
      bus(1, 0, 4'h1, 8'h20);
      bus(1, 0, 4'h3, 8'hff);
      bus(0, 0, 4'h0, 8'h00);
      n = 0;
      repeat (2500) @(posedge clk) #1 n += rb;
      chk("dpll recentred pulses", n[15:0], 16'h0000);
      report_and_stop();
   end
endmodule // brg_dpll_bench
